// ---- bench/sdbr_regs_assertions.sv ----
// Purpose: port checker for the buffering and sync delay register slice
// Assumes: zero wait-state APB slave, one clock domain
// Notes:   bound to sdbr_regs below the module
`timescale 1ns/10ps
`default_nettype none
module sdbr_regs_assertions (
   // clock and reset
   input  wire logic                        CORE_CLK_IN,
   input  wire logic                        NRST_IN,
   // apb
   input  wire logic                        PSEL_IN,
   input  wire logic                        PENABLE_IN,
   input  wire logic                        PWRITE_IN,
   input  wire logic [sdbr_pkg::ADDR_W-1:0] PADDR_IN,
   input  wire logic [31:0]                 PWDATA_IN,
   input  wire logic [31:0]                 PRDATA_OUT,
   input  wire logic                        PREADY_OUT,
   input  wire logic                        PSLVERR_OUT,
   // sync and settings
   input  wire logic                        SYNC_PIN_IN,
   input  wire logic [15:0]                 ACTIVE_SEL_OUT,
   input  wire logic                        SYNC_RELEASE_OUT
);
   // ----------------------------------------------------------------
   // bus phases and checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!NRST_IN);
   wire logic in_slice = PADDR_IN >= 10'h0f8 && PADDR_IN <= 10'h118 && PADDR_IN[1:0] == 2'b00;
   sequence s_setup;
      PSEL_IN && !PENABLE_IN;
   endsequence
   sequence s_read_acc;
      PSEL_IN && PENABLE_IN && !PWRITE_IN;
   endsequence
   a_ready_access: assert property (s_setup |=> PREADY_OUT)
      else $error("access phase without ready");
   a_err_setup: assert property (s_setup |-> !PSLVERR_OUT)
      else $error("error flag in setup phase");
   a_err_misalign: assert property (PSEL_IN && PENABLE_IN && PADDR_IN[1:0] != 2'b00 |-> PSLVERR_OUT)
      else $error("misaligned access not refused");
   a_err_slice: assert property (PSEL_IN && PENABLE_IN && in_slice |-> !PSLVERR_OUT)
      else $error("mapped access refused");
   a_refused_zero: assert property (s_read_acc ##0 PSLVERR_OUT |-> PRDATA_OUT == 32'h0)
      else $error("refused read returns data");
   a_upper_zero: assert property (s_read_acc ##0 in_slice |-> PRDATA_OUT[31:16] == 16'h0)
      else $error("reserved upper bits nonzero");
   a_release_single: assert property ($rose(SYNC_RELEASE_OUT) |=> !SYNC_RELEASE_OUT)
      else $error("release pulse longer than one cycle");
   a_active_write: assert property (!$stable(ACTIVE_SEL_OUT) |-> $past(PSEL_IN && PWRITE_IN))
      else $error("active setting changed without a write");
endmodule : sdbr_regs_assertions
bind sdbr_regs sdbr_regs_assertions sdbr_regs_assertions_i (.CORE_CLK_IN(CORE_CLK_IN),
   .NRST_IN(NRST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
   .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
   .PSLVERR_OUT(PSLVERR_OUT), .SYNC_PIN_IN(SYNC_PIN_IN), .ACTIVE_SEL_OUT(ACTIVE_SEL_OUT),
   .SYNC_RELEASE_OUT(SYNC_RELEASE_OUT));
`default_nettype wire

// ---- bench/sdbr_regs_tb.sv ----
// Purpose: self-checking bench for the buffering and sync delay registers
// Assumes: APB master in the bench, seeded random stimulus
// Notes:   delay count kept small through the low count half
`timescale 1ns/10ps
`default_nettype none
module sdbr_regs_tb;
   import sdbr_pkg::*;
   logic              clk, nrst, psel, penable, pwrite, sync, e;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, q, v;
   wire logic [31:0]  prdata;
   wire logic         pready, pslverr, rel;
   wire logic [15:0]  act_sel;
   logic [15:0]       act [6];
   logic [5:0]        en;
   int                error_cnt, check_count, seed, k, n, f;
   const logic [15:0] rv [9] = '{16'h00af, 16'h0, 16'h1388, 16'h0, 16'h01f4, 16'h0, 16'h03e8,
                                 16'h0, 16'hc350};
   sdbr_regs sdbr_regs_i (.CORE_CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SYNC_PIN_IN(sync),
      .ACTIVE_SEL_OUT(act_sel), .SYNC_RELEASE_OUT(rel));
   // ----------------------------------------------------------------
   // clock, watchdog and helpers
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      conclude();
   end
   // a function is held in its shadow when its enable, and bit 13 for the ref ones, is set
   function automatic logic buffered(input logic [5:0] m, input int g);
      return (g < 3) ? m[5-g] : (m[5-g] && m[3]);
   endfunction : buffered
   function automatic logic in_win(input int cnt, input int len, input int c);
      return cnt >= (len << c) && cnt <= (len << c) + 8 + (1 << c);
   endfunction : in_win
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, x, g);
      end
   endtask : chk
   // one transfer, held until ready is seen at an edge
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      apb(1'b1, {i, 2'b00}, d);
   endtask : wr
   task automatic rd(input logic [7:0] i, input logic [31:0] x);
      apb(1'b0, {i, 2'b00}, 32'h0);
      chk($sformatf("reg %h", i), x, q);
      chk("slverr", 32'h0, {31'h0, e});
   endtask : rd
   task automatic conclude();
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 28165;
      {nrst, psel, penable, pwrite, sync, paddr, pwdata} = '0;
      act = '{default: 16'h0};
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      for (int r = 0; r < 9; r++) rd(8'(8'h3e + r), {16'h0, rv[r]});
      chk("active port", 32'h0, {16'h0, act_sel});
      // host rewrites fixed values, count halves get random words
      for (int r = 0; r < 7; r++) wr(8'(8'h3e + r), {16'h0, rv[r]});
      for (int r = 7; r < 9; r++) begin
         v = $random(seed);
         wr(8'(8'h3e + r), v);
         rd(8'(8'h3e + r), {16'h0, v[15:0]});
      end
      wr(IDX_SW_CTRL, 32'h1);
      for (int r = 0; r < 9; r++) rd(8'(8'h3e + r), {16'h0, rv[r]});
      // refused places leave the slice alone
      apb(1'b0, 10'h180, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
      apb(1'b1, 10'h0f9, 32'hffff);
      chk("misaligned err", 32'h1, {31'h0, e});
      apb(1'b0, 10'h0fa, 32'h0);
      chk("misaligned rd err", 32'h1, {31'h0, e});
      chk("misaligned rd data", 32'h0, q);
      rd(IDX_BUF_CTRL, 32'h00af);
      // staged writes per function, corners first, then random enables
      for (int i = 0; i < 24; i++) begin
         f = i % 6;
         en = (i < 6) ? 6'b110111 : (i < 12) ? 6'b001111 : 6'($random(seed));
         wr(IDX_BUF_CTRL, {16'h0, en, 10'h0af});
         v = $random(seed);
         v[31:16] = {13'h0, 3'(f)};
         wr(IDX_STAGE, v);
         rd(IDX_ACTIVE, {16'h0, buffered(en, f) ? act[f] : v[15:0]});
         if (buffered(en, f)) rd(IDX_STAGE, v);
         if (f == 0) chk("active port", buffered(en, f) ? act[0] : v[15:0], act_sel);
         wr(IDX_SW_CTRL, 32'h2);
         rd(IDX_ACTIVE, {16'h0, v[15:0]});
         if (f == 0) chk("active port", v[15:0], act_sel);
         act[f] = v[15:0];
      end
      // sync delay over three divider settings
      for (int c = 0; c < 3; c++) begin
         n = 8 + ($random(seed) & 31);
         wr(IDX_DLY_HIGH, 32'h0);
         wr(IDX_DLY_LOW, 32'(n));
         wr(IDX_SW_CTRL, 32'(c << 4));
         @(posedge clk);
         sync <= 1'b1;
         k = 0;
         while (rel !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k++;
         end
         sync <= 1'b0;
         chk("sync delay", 32'h1, {31'h0, in_win(k, n, c)});
         @(posedge clk);
         chk("release end", 32'h0, {31'h0, rel});
      end
      // a long count: upper half busy while it runs, then a mid-run reset cuts it
      wr(IDX_DLY_HIGH, 32'h1);
      wr(IDX_DLY_LOW, 32'hffff);
      sync <= 1'b1;
      repeat (4) @(posedge clk);
      rd(IDX_STATUS, 32'h0001_0100);
      sync <= 1'b0;
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      chk("release in reset", 32'h0, {31'h0, rel});
      chk("active in reset", 32'h0, {16'h0, act_sel});
      nrst <= 1'b1;
      rd(IDX_DLY_HIGH, 32'h0);
      rd(IDX_STATUS, 32'h0);
      conclude();
   end
endmodule : sdbr_regs_tb
`default_nettype wire

// ---- rtl/sdbr_pkg.sv ----
// Purpose: constants for the synthesizer buffering and sync delay register slice
// Assumes: APB with 32-bit data, 16-bit registers in the low half of each word
// Notes:   printed offsets are register indices; byte address is four times index
package sdbr_pkg;
   // ----------------------------------------------------------------
   // register indices and address width
   // ----------------------------------------------------------------
   localparam logic [7:0]  IDX_BUF_CTRL    = 8'h3e;
   localparam logic [7:0]  IDX_ZERO_A      = 8'h3f;
   localparam logic [7:0]  IDX_VALUE_A     = 8'h40;
   localparam logic [7:0]  IDX_ZERO_B      = 8'h41;
   localparam logic [7:0]  IDX_VALUE_B     = 8'h42;
   localparam logic [7:0]  IDX_ZERO_C      = 8'h43;
   localparam logic [7:0]  IDX_VALUE_C     = 8'h44;
   localparam logic [7:0]  IDX_DLY_HIGH    = 8'h45;
   localparam logic [7:0]  IDX_DLY_LOW     = 8'h46;
   localparam logic [7:0]  IDX_SW_CTRL     = 8'h50;
   localparam logic [7:0]  IDX_STAGE       = 8'h51;
   localparam logic [7:0]  IDX_ACTIVE      = 8'h52;
   localparam logic [7:0]  IDX_STATUS      = 8'h53;
   localparam int          ADDR_W          = 10;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int          BIT_MOD_ORDER   = 15;
   localparam int          BIT_FRAC_NUM    = 14;
   localparam int          BIT_INT_DIV     = 13;
   localparam int          BIT_REF_DIVS    = 12;
   localparam int          BIT_REF_MULT    = 11;
   localparam int          BIT_REF_DBL     = 10;
   localparam int          BIT_SW_RESET    = 0;
   localparam int          BIT_COMMIT      = 1;
   localparam int          BIT_CAL_DIV_LO  = 4;
   localparam int          NUM_FUNCS       = 6;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_BUF_CTRL    = 16'h00af;
   localparam logic [15:0] RST_ZERO        = 16'h0000;
   localparam logic [15:0] RST_VALUE_A     = 16'h1388;
   localparam logic [15:0] RST_VALUE_B     = 16'h01f4;
   localparam logic [15:0] RST_VALUE_C     = 16'h03e8;
   localparam logic [15:0] RST_DLY_HIGH    = 16'h0000;
   localparam logic [15:0] RST_DLY_LOW     = 16'hc350;
   localparam logic [2:0]  RST_CAL_DIV     = 3'h0;
   // sync counter states
   typedef enum logic [1:0] {
      SDBR_IDLE  = 2'b00,
      SDBR_COUNT = 2'b01,
      SDBR_DONE  = 2'b10
   } sdbr_sync_e;
endpackage : sdbr_pkg

// ---- rtl/sdbr_regs.sv ----
// Purpose: buffering-control, fixed-value and sync delay registers over APB
// Assumes: single clock, APB slave answering with zero wait states
// Notes:   settings arrive one function at a time through a staging register
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module sdbr_regs (
   // clock and reset
   input  wire logic                             CORE_CLK_IN,
   input  wire logic                             NRST_IN,
   // apb slave
   input  wire logic                             PSEL_IN,
   input  wire logic                             PENABLE_IN,
   input  wire logic                             PWRITE_IN,
   input  wire logic [sdbr_pkg::ADDR_W-1:0]      PADDR_IN,
   input  wire logic [31:0]                      PWDATA_IN,
   output logic      [31:0]                      PRDATA_OUT,
   output logic                                  PREADY_OUT,
   output logic                                  PSLVERR_OUT,
   // phase sync request pin
   input  wire logic                             SYNC_PIN_IN,
   // active modulator order setting and sync release
   output logic      [15:0]                      ACTIVE_SEL_OUT,
   output logic                                  SYNC_RELEASE_OUT
);
   import sdbr_pkg::*;

   // ----------------------------------------------------------------
   // register map (byte address is four times the index)
   // ----------------------------------------------------------------
   // 0x0f8 buffering control: 15:10 enables, 9:0 fixed pattern
   // 0x0fc fixed zero a
   // 0x100 fixed value a
   // 0x104 fixed zero b
   // 0x108 fixed value b
   // 0x10c fixed zero c
   // 0x110 fixed value c
   // 0x114 sync delay count, upper half
   // 0x118 sync delay count, lower half
   // 0x140 control: 0 soft reset, 1 commit, 6:4 tick exponent
   // 0x144 staging: 18:16 function, 15:0 value; reads back the shadow
   // 0x148 active setting of the staged function
   // 0x14c status: 16 upper count busy, 9:8 sync state, 5:0 pending
   // functions: 0 modulator order, 1 fractional numerator,
   // 2 integer divider, 3 ref dividers, 4 ref multiplier, 5 doubler
   // every register reads in bits 15:0 with zeros above, except status
   // and staging; unmapped or misaligned places raise the error flag

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      // software visible registers
      logic [15:0]                buf_ctrl;
      logic [15:0]                zero_a;
      logic [15:0]                value_a;
      logic [15:0]                zero_b;
      logic [15:0]                value_b;
      logic [15:0]                zero_c;
      logic [15:0]                value_c;
      logic [15:0]                dly_high;
      logic [15:0]                dly_low;
      // control fields
      logic [2:0]                 cal_div;
      logic [2:0]                 stage_sel;
      // double buffering per function
      logic [NUM_FUNCS-1:0][15:0] shadow;
      logic [NUM_FUNCS-1:0][15:0] active;
      logic [NUM_FUNCS-1:0]       pending;
      // phase sync delay
      sdbr_sync_e                 sync_state;
      logic [31:0]                dly_cnt;
      logic [7:0]                 tick_cnt;
      // pin synchroniser and edge history
      logic                       sync_m1;
      logic                       sync_m2;
      logic                       sync_prev;
      logic                       release_q;
      // read data fetched on the setup edge
      logic [31:0]                rdata;
   } sdbr_state_s;

   sdbr_state_s                cur;
   sdbr_state_s                next_st;
   logic                       wr_acc;
   logic                       rd_setup;
   logic [7:0]                 reg_idx;
   logic                       idx_ok;
   logic                       addr_ok;
   logic [NUM_FUNCS-1:0]       buf_en;
   logic [15:0]                wdata16;
   logic                       tick;
   logic [7:0]                 tick_last;
   logic                       sync_edge;
   logic                       cnt_busy;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // apb access phase completes in one cycle, no wait states
   // the slave never stalls, so ready is tied high; a refused access
   // still completes, with the error flag raised in its access phase
   // and any write data dropped
   // reads are fetched on the setup edge so that the data stands
   // through the whole access phase
   assign wr_acc      = PSEL_IN & PENABLE_IN & PWRITE_IN;
   assign rd_setup    = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
   assign reg_idx     = PADDR_IN[ADDR_W-1:2];
   assign addr_ok     = (PADDR_IN[1:0] == 2'h0) & idx_ok;
   assign wdata16     = PWDATA_IN[15:0];
   assign PREADY_OUT  = 1'b1;
   assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_ok;
   assign PRDATA_OUT  = cur.rdata;

   // status and readback places are mapped, so reading them is no error
   // decode index to a mapped register
   always_comb begin
      case (reg_idx)
         IDX_BUF_CTRL, IDX_ZERO_A, IDX_VALUE_A, IDX_ZERO_B, IDX_VALUE_B,
         IDX_ZERO_C, IDX_VALUE_C, IDX_DLY_HIGH, IDX_DLY_LOW,
         IDX_SW_CTRL, IDX_STAGE, IDX_ACTIVE, IDX_STATUS: idx_ok = 1'b1;
         default: idx_ok = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // effective buffering enables
   // ----------------------------------------------------------------
   // index 0 modulator order ... index 5 reference doubler
   // the three reference path enables only count while the integer
   // divider enable is set; a reference enable alone lets those
   // settings apply at once
   assign buf_en[0] = cur.buf_ctrl[BIT_MOD_ORDER];
   assign buf_en[1] = cur.buf_ctrl[BIT_FRAC_NUM];
   assign buf_en[2] = cur.buf_ctrl[BIT_INT_DIV];
   assign buf_en[3] = cur.buf_ctrl[BIT_REF_DIVS] & cur.buf_ctrl[BIT_INT_DIV];
   assign buf_en[4] = cur.buf_ctrl[BIT_REF_MULT] & cur.buf_ctrl[BIT_INT_DIV];
   assign buf_en[5] = cur.buf_ctrl[BIT_REF_DBL] & cur.buf_ctrl[BIT_INT_DIV];

   // state machine clock tick every 2^cal_div core cycles
   // the compare is >= rather than ==: lowering the exponent while the
   // tick counter stands above the new limit must not let it run all
   // the way round its eight bits before the next tick
   assign tick_last = 8'((16'h1 << cur.cal_div) - 16'h1);
   assign tick      = (cur.tick_cnt >= tick_last);

   // rising edge of the synchronised pin; the history flop idles low
   // like the pin, so leaving reset gives no false edge
   assign sync_edge = cur.sync_m2 & ~cur.sync_prev;
   // upper half of the running count not yet drained, for status
   assign cnt_busy  = (cur.dly_cnt[31:16] != 16'h0);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = cur;
      // synchroniser for the sync pin; the pin is asynchronous, so only
      // the second stage feeds any logic
      next_st.sync_m1   = SYNC_PIN_IN;
      next_st.sync_m2   = cur.sync_m1;
      next_st.sync_prev = cur.sync_m2;
      next_st.release_q = 1'b0;
      next_st.tick_cnt  = tick ? 8'h0 : 8'(cur.tick_cnt + 8'h1);

      // register writes
      // fixed-value registers keep whatever is written; holding them at
      // their required values is the duty of the host
      if (wr_acc & addr_ok) begin
         case (reg_idx)
            IDX_BUF_CTRL: next_st.buf_ctrl = wdata16;
            IDX_ZERO_A:   next_st.zero_a   = wdata16;
            IDX_VALUE_A:  next_st.value_a  = wdata16;
            IDX_ZERO_B:   next_st.zero_b   = wdata16;
            IDX_VALUE_B:  next_st.value_b  = wdata16;
            IDX_ZERO_C:   next_st.zero_c   = wdata16;
            IDX_VALUE_C:  next_st.value_c  = wdata16;
            IDX_DLY_HIGH: next_st.dly_high = wdata16;
            IDX_DLY_LOW:  next_st.dly_low  = wdata16;
            IDX_STAGE: begin
               // an index above five is kept for readback, stores nothing
               next_st.stage_sel = PWDATA_IN[18:16];
               if (PWDATA_IN[18:16] < 3'(NUM_FUNCS)) begin
                  // buffered function waits in its shadow, else applies now
                  if (buf_en[PWDATA_IN[18:16]]) begin
                     next_st.shadow[PWDATA_IN[18:16]]  = wdata16;
                     next_st.pending[PWDATA_IN[18:16]] = 1'b1;
                  end else begin
                     next_st.active[PWDATA_IN[18:16]]  = wdata16;
                  end
               end
            end
            IDX_SW_CTRL: begin
               // commit and soft reset in one write: shadows move first,
               // then the reset drops every pending flag
               next_st.cal_div = PWDATA_IN[BIT_CAL_DIV_LO+2:BIT_CAL_DIV_LO];
               if (PWDATA_IN[BIT_COMMIT]) begin
                  // commit moves every pending shadow to the active setting
                  for (int i = 0; i < NUM_FUNCS; i++) begin
                     if (cur.pending[i]) begin
                        next_st.active[i] = cur.shadow[i];
                     end
                  end
                  next_st.pending = '0;
               end
               if (PWDATA_IN[BIT_SW_RESET]) begin
                  // software reset restores the fixed-value registers
                  next_st.buf_ctrl = RST_BUF_CTRL;
                  next_st.zero_a   = RST_ZERO;
                  next_st.value_a  = RST_VALUE_A;
                  next_st.zero_b   = RST_ZERO;
                  next_st.value_b  = RST_VALUE_B;
                  next_st.zero_c   = RST_ZERO;
                  next_st.value_c  = RST_VALUE_C;
                  next_st.dly_high = RST_DLY_HIGH;
                  next_st.dly_low  = RST_DLY_LOW;
                  next_st.pending  = '0;
               end
            end
            default: ;
         endcase
      end

      // phase sync delay counter
      // a zero count releases three cycles after the edge is seen; an
      // edge that arrives while a delay runs is ignored, not queued
      case (cur.sync_state)
         SDBR_IDLE: begin
            if (sync_edge) begin
               next_st.dly_cnt    = {cur.dly_high, cur.dly_low};
               next_st.sync_state = SDBR_COUNT;
            end
         end
         SDBR_COUNT: begin
            if (cur.dly_cnt == 32'h0) begin
               next_st.sync_state = SDBR_DONE;
            end else if (tick) begin
               next_st.dly_cnt = cur.dly_cnt - 32'h1;
            end
         end
         SDBR_DONE: begin
            // one-cycle release pulse, then back to waiting for an edge
            next_st.release_q  = 1'b1;
            next_st.sync_state = SDBR_IDLE;
         end
         default: next_st.sync_state = SDBR_IDLE;
      endcase

      // read data captured in setup phase, valid during access; a
      // refused read fetches nothing, so its access phase returns zero
      next_st.rdata = 32'h0;
      if (rd_setup & addr_ok) begin
         case (reg_idx)
            IDX_BUF_CTRL: next_st.rdata = {16'h0, cur.buf_ctrl};
            IDX_ZERO_A:   next_st.rdata = {16'h0, cur.zero_a};
            IDX_VALUE_A:  next_st.rdata = {16'h0, cur.value_a};
            IDX_ZERO_B:   next_st.rdata = {16'h0, cur.zero_b};
            IDX_VALUE_B:  next_st.rdata = {16'h0, cur.value_b};
            IDX_ZERO_C:   next_st.rdata = {16'h0, cur.zero_c};
            IDX_VALUE_C:  next_st.rdata = {16'h0, cur.value_c};
            IDX_DLY_HIGH: next_st.rdata = {16'h0, cur.dly_high};
            IDX_DLY_LOW:  next_st.rdata = {16'h0, cur.dly_low};
            IDX_SW_CTRL:  next_st.rdata = {25'h0, cur.cal_div, 4'h0};
            IDX_STAGE:    next_st.rdata = {13'h0, cur.stage_sel,
                                           (cur.stage_sel < 3'(NUM_FUNCS)) ?
                                           cur.shadow[cur.stage_sel] : 16'h0};
            IDX_ACTIVE:   next_st.rdata = {16'h0,
                                           (cur.stage_sel < 3'(NUM_FUNCS)) ?
                                           cur.active[cur.stage_sel] : 16'h0};
            // status: 16 upper count busy, 9:8 sync state, 5:0 pending
            IDX_STATUS:   next_st.rdata = {15'h0, cnt_busy, 6'h0, cur.sync_state,
                                           2'h0, cur.pending};
            default:      next_st.rdata = 32'h0;
         endcase
      end
   end

   // active modulator order setting, straight from its register, so a
   // commit shows on the port at the edge that moves the shadow
   assign ACTIVE_SEL_OUT   = cur.active[0];
   assign SYNC_RELEASE_OUT = cur.release_q;

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // the reset branch loads constants only; the shadows, active
   // settings, pending flags and counters all start from zero
   always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         cur            <= '0;
         cur.buf_ctrl   <= RST_BUF_CTRL;
         cur.zero_a     <= RST_ZERO;
         cur.value_a    <= RST_VALUE_A;
         cur.zero_b     <= RST_ZERO;
         cur.value_b    <= RST_VALUE_B;
         cur.zero_c     <= RST_ZERO;
         cur.value_c    <= RST_VALUE_C;
         cur.dly_high   <= RST_DLY_HIGH;
         cur.dly_low    <= RST_DLY_LOW;
         cur.cal_div    <= RST_CAL_DIV;
         cur.sync_state <= SDBR_IDLE;
      end else begin
         cur <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // limitations
   // ----------------------------------------------------------------
   // the delay counts ticks of 2^exponent core cycles; any divide of
   // the reference input ahead of this block is outside it
   // a full 32-bit count at the slowest tick outlasts any practical
   // run, so keep the upper half small when exercising the delay
   // choosing a delay of several loop lock times is left to the host
   // only the modulator order setting leaves as a port; the others
   // are seen through the active readback place
   // writes to the status and active readback places are accepted
   // without effect and raise no error
   // the fixed-value registers are storage only; nothing here checks
   // that the host has written the required patterns
   // a soft reset also restores both count halves and drops pending
   // shadows, but leaves the active settings as they were
endmodule : sdbr_regs
`default_nettype wire
